// ==== design/pscd_pkg.sv ====
// Package: register map, field positions, reset values and link states
// Operation
// - Each converter stores two five-bit level codes; the active one is its target.
// - Converter 2 uses level b when general bit 3 is 0, else level a.
// - Converter 1 with general bit 2 clear follows pin: low b, high a.
// - One bit per clock pulse, sampled high; data changes only while clock low.
// - A data change while clock high mid-transaction abandons the transaction.
// - Bytes are eight bits, most significant bit first.
// - Receiver acknowledges every byte during the ninth master clock.
// - Data falling while clock high is a start; it begins a transaction.
// - Data rising while clock high is a stop; it ends the transaction.
// - Bus counts as busy from start until after the stop.
// - A repeated start mid-transaction is accepted, turning a read around.
// - Clock generator is master; device is slave with its own address.
// - First seven bits are address, eighth is direction; ack only on match.
// - Write: first byte is register index, later bytes go to incrementing index.
// - Read: send indexed register, advance index on master ack; nack then stop.
// - Transmitter releases data in ninth clock; receiver holds it low while high.
package pscd_pkg;

  localparam int          LEVEL_W      = 5;
  localparam logic [7:0]  OFS_GENERAL  = 8'h00;
  localparam logic [7:0]  OFS_C1_A     = 8'h08;
  localparam logic [7:0]  OFS_C1_B     = 8'h09;
  localparam logic [7:0]  OFS_C2_A     = 8'h0A;
  localparam logic [7:0]  OFS_C2_B     = 8'h0B;
  localparam int          C1_SEL_BIT   = 2;
  localparam int          C2_SEL_BIT   = 3;
  localparam logic [7:0]  RST_REG      = 8'h00;
  localparam logic [3:0]  LAST_BIT_CNT = 4'h7;
  localparam logic [3:0]  ACK_BIT_CNT  = 4'h8;

  // Link protocol states, one-hot
  typedef enum logic [5:0] {
    PSCD_IDLE   = 6'h01,
    PSCD_ADDR   = 6'h02,
    PSCD_INDEX  = 6'h04,
    PSCD_WDATA  = 6'h08,
    PSCD_RDATA  = 6'h10,
    PSCD_IGNORE = 6'h20
  } pscd_state_t;

endpackage : pscd_pkg

// ==== design/pscd_link_if.sv ====
// Interface: bits captured on the serial clock, handed to the core domain
`timescale 1ns/1ps
interface pscd_link_if;
  logic       bit_toggle;
  logic [7:0] shreg;
  modport cap  (output bit_toggle, output shreg);
  modport core (input bit_toggle, input shreg);
endinterface : pscd_link_if

// ==== design/pscd_bit_capture.sv ====
// Serial-clock domain: samples the data line on each rising clock edge
`timescale 1ns/1ps
module pscd_bit_capture
  (
  // Link clock and clear
  input wire logic  scl,
  input wire logic  clr,
  // Data pin
  input wire logic  sda_in,
  // Toward the core domain
  pscd_link_if.cap  link
  );

  logic [7:0] next_shreg;
  logic       next_toggle;

  // Shift in from the bottom so the first bit ends up as the top bit
  always_comb
  begin
    next_shreg  = {link.shreg[6:0], sda_in};
    next_toggle = ~link.bit_toggle;
  end

  // Clock may stand still, so the clear cannot wait for an edge
  always_ff @(posedge scl or posedge clr)
  begin
    if (clr)
    begin
      link.shreg      <= 8'h00;
      link.bit_toggle <= 1'b0;
    end
    else
    begin
      link.shreg      <= next_shreg;
      link.bit_toggle <= next_toggle;
    end
  end

endmodule : pscd_bit_capture

// ==== design/pscd_level_select.sv ====
// Voltage level selection for the two step-down converters
`timescale 1ns/1ps
module pscd_level_select
  (
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst,
  // Register contents and pin
  input wire logic [7:0]              general_control,
  input wire logic [7:0]              conv1_level_a,
  input wire logic [7:0]              conv1_level_b,
  input wire logic [7:0]              conv2_level_a,
  input wire logic [7:0]              conv2_level_b,
  input wire logic                    scaling_select_pin,
  // Targets
  output logic [pscd_pkg::LEVEL_W-1:0] conv1_target,
  output logic [pscd_pkg::LEVEL_W-1:0] conv2_target
  );
  import pscd_pkg::*;

  logic [LEVEL_W-1:0] next_conv1;
  logic [LEVEL_W-1:0] next_conv2;

  // Converter 1 obeys the pin whatever bit 2 says; that case awaits review
  always_comb
  begin
    next_conv1 = scaling_select_pin ? conv1_level_a[LEVEL_W-1:0]
                                    : conv1_level_b[LEVEL_W-1:0];
    next_conv2 = general_control[C2_SEL_BIT] ? conv2_level_a[LEVEL_W-1:0]
                                             : conv2_level_b[LEVEL_W-1:0];
  end

  // Registered so the targets never glitch during a register update
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      conv1_target <= RST_REG[LEVEL_W-1:0];
      conv2_target <= RST_REG[LEVEL_W-1:0];
    end
    else
    begin
      conv1_target <= next_conv1;
      conv2_target <= next_conv2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_conv2_sel;
    (!general_control[C2_SEL_BIT]) |=> conv2_target == $past(conv2_level_b[LEVEL_W-1:0]);
  endproperty
  a_conv2_sel: assert property (p_conv2_sel) else $error("conv2 not on level b");

  property p_conv1_pin;
    (!general_control[C1_SEL_BIT] && !scaling_select_pin)
      |=> conv1_target == $past(conv1_level_b[LEVEL_W-1:0]);
  endproperty
  a_conv1_pin: assert property (p_conv1_pin) else $error("conv1 not on level b");

  property p_conv1_override;
    (general_control[C1_SEL_BIT] && scaling_select_pin)
      |=> conv1_target == $past(conv1_level_a[LEVEL_W-1:0]);
  endproperty
  a_conv1_override: assert property (p_conv1_override) else $error("conv1 bad");

  property p_conv_field;
    ##1 (conv2_target == $past(conv2_level_a[LEVEL_W-1:0])
      || conv2_target == $past(conv2_level_b[LEVEL_W-1:0]));
  endproperty
  a_conv_field: assert property (p_conv_field) else $error("conv2 off field");

endmodule : pscd_level_select

// ==== design/pscd_top.sv ====
// Serial register port and converter level selection of the power unit
`timescale 1ns/1ps
module pscd_top
  #(
  // Bus address; default value is arbitrary
  parameter logic [6:0] SLAVE_ADDR = 7'h2A
  )
  (
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst,
  // Serial link pins
  input wire logic                    scl,
  input wire logic                    sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Level select pin
  input wire logic                    scaling_select_pin,
  // Converter targets and status
  output logic [pscd_pkg::LEVEL_W-1:0] conv1_target,
  output logic [pscd_pkg::LEVEL_W-1:0] conv2_target,
  output logic                        bus_busy
  );
  import pscd_pkg::*;

  pscd_link_if link ();

  logic [2:0]  sync_a;
  logic [2:0]  sync_b;
  logic [2:0]  sync_c;
  logic [2:0]  filt;
  logic [2:0]  filt_d;
  logic [2:0]  tog_s;
  logic [2:0]  next_filt;
  logic        scl_f;
  logic        sda_f;
  logic        start_evt;
  logic        stop_evt;
  logic        scl_fall;
  logic        tog_evt;
  logic        commit;
  pscd_state_t state;
  pscd_state_t next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  index;
  logic [7:0]  next_index;
  logic        ack_pending;
  logic        next_ack;
  logic        dir;
  logic        next_dir;
  logic [7:0]  wdata;
  logic [7:0]  next_wdata;
  logic [7:0]  tx_byte;
  logic [7:0]  next_tx;
  logic        next_oe;
  logic        next_busy;
  logic [7:0]  general_control;
  logic [7:0]  conv1_level_a;
  logic [7:0]  conv1_level_b;
  logic [7:0]  conv2_level_a;
  logic [7:0]  conv2_level_b;
  logic [7:0]  next_gen;
  logic [7:0]  next_c1a;
  logic [7:0]  next_c1b;
  logic [7:0]  next_c2a;
  logic [7:0]  next_c2b;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode, shared by reads and checks
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    case (idx)
      OFS_GENERAL: reg_read = general_control;
      OFS_C1_A:    reg_read = conv1_level_a;
      OFS_C1_B:    reg_read = conv1_level_b;
      OFS_C2_A:    reg_read = conv2_level_a;
      OFS_C2_B:    reg_read = conv2_level_b;
      default:     reg_read = 8'h00;
    endcase
  endfunction : reg_read

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == OFS_GENERAL) || (idx == OFS_C1_A) || (idx == OFS_C1_B)
             || (idx == OFS_C2_A) || (idx == OFS_C2_B);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain samples the data line
  pscd_bit_capture u_capture (
    .scl    (scl),
    .clr    (rst),
    .sda_in (sda_in),
    .link   (link.cap)
  );

  // Open drain: only ever pull low
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter: a level counts once the second and third stages agree
  always_comb
  begin
    next_filt = (~(sync_b ^ sync_c) & sync_c) | ((sync_b ^ sync_c) & filt);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync_a <= 3'h3;
      sync_b <= 3'h3;
      sync_c <= 3'h3;
      filt   <= 3'h3;
      filt_d <= 3'h3;
      tog_s  <= 3'h0;
    end
    else
    begin
      sync_a <= {scaling_select_pin, sda_in, scl};
      sync_b <= sync_a;
      sync_c <= sync_b;
      filt   <= next_filt;
      filt_d <= filt;
      tog_s  <= {tog_s[1:0], link.bit_toggle};
    end
  end

  // Bit events; shift data is stable for a whole clock once the toggle lands
  assign scl_f     = filt[0];
  assign sda_f     = filt[1];
  assign start_evt = filt_d[0] & scl_f & filt_d[1] & ~sda_f;
  assign stop_evt  = filt_d[0] & scl_f & ~filt_d[1] & sda_f;
  assign scl_fall  = filt_d[0] & ~scl_f;
  assign tog_evt   = tog_s[1] ^ tog_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_comb
  begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_index   = index;
    next_ack     = ack_pending;
    next_dir     = dir;
    next_wdata   = wdata;
    next_tx      = tx_byte;
    next_oe      = sda_oe;
    next_busy    = bus_busy;
    if (start_evt)
    begin
      // Also a repeated start; any change while high aborts what ran
      next_state   = PSCD_ADDR;
      next_bit_cnt = 4'h0;
      next_ack     = 1'b0;
      next_oe      = 1'b0;
      next_busy    = 1'b1;
    end
    else if (stop_evt)
    begin
      next_state = PSCD_IDLE;
      next_ack   = 1'b0;
      next_oe    = 1'b0;
      next_busy  = 1'b0;
    end
    else
    begin
      if (tog_evt && state != PSCD_IDLE)
      begin
        if (bit_cnt == ACK_BIT_CNT)
        begin
          next_bit_cnt = 4'h0;
          next_ack     = 1'b0;
          case (state)
            PSCD_ADDR:
            begin
              next_state = dir ? PSCD_RDATA : PSCD_INDEX;
              next_tx    = reg_read(index);
            end
            PSCD_INDEX: next_state = PSCD_WDATA;
            PSCD_WDATA: next_index = 8'(index + 8'h01);
            PSCD_RDATA:
            begin
              if (!link.shreg[0])
              begin
                next_index = 8'(index + 8'h01);
                next_tx    = reg_read(8'(index + 8'h01));
              end
              else
                next_state = PSCD_IGNORE;
            end
            default: next_state = state;
          endcase
        end
        else
        begin
          next_bit_cnt = 4'(bit_cnt + 4'h1);
          if (bit_cnt == LAST_BIT_CNT)
          begin
            case (state)
              PSCD_ADDR:
              begin
                if (link.shreg[7:1] == SLAVE_ADDR)
                begin
                  next_ack = 1'b1;
                  next_dir = link.shreg[0];
                end
                else
                  next_state = PSCD_IGNORE;
              end
              PSCD_INDEX:
              begin
                next_index = link.shreg;
                next_ack   = 1'b1;
              end
              PSCD_WDATA:
              begin
                next_wdata = link.shreg;
                next_ack   = 1'b1;
              end
              default: next_ack = ack_pending;
            endcase
          end
        end
      end
      // Drive only just after a falling clock edge
      if (scl_fall)
      begin
        if (bit_cnt == ACK_BIT_CNT)
          next_oe = ack_pending;
        else if (state == PSCD_RDATA)
          next_oe = ~tx_byte[~bit_cnt[2:0]];
        else
          next_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state       <= PSCD_IDLE;
      bit_cnt     <= 4'h0;
      index       <= RST_REG;
      ack_pending <= 1'b0;
      dir         <= 1'b0;
      wdata       <= RST_REG;
      tx_byte     <= RST_REG;
      sda_oe      <= 1'b0;
      bus_busy    <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      index       <= next_index;
      ack_pending <= next_ack;
      dir         <= next_dir;
      wdata       <= next_wdata;
      tx_byte     <= next_tx;
      sda_oe      <= next_oe;
      bus_busy    <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; a data byte lands as its acknowledge starts
  assign commit = scl_fall && !start_evt && !stop_evt && bit_cnt == ACK_BIT_CNT
               && ack_pending && state == PSCD_WDATA;

  always_comb
  begin
    next_gen = general_control;
    next_c1a = conv1_level_a;
    next_c1b = conv1_level_b;
    next_c2a = conv2_level_a;
    next_c2b = conv2_level_b;
    if (commit)
    begin
      case (index)
        OFS_GENERAL: next_gen = wdata;
        OFS_C1_A:    next_c1a = wdata;
        OFS_C1_B:    next_c1b = wdata;
        OFS_C2_A:    next_c2a = wdata;
        OFS_C2_B:    next_c2b = wdata;
        default:     next_gen = general_control;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      general_control <= RST_REG;
      conv1_level_a   <= RST_REG;
      conv1_level_b   <= RST_REG;
      conv2_level_a   <= RST_REG;
      conv2_level_b   <= RST_REG;
    end
    else
    begin
      general_control <= next_gen;
      conv1_level_a   <= next_c1a;
      conv1_level_b   <= next_c1b;
      conv2_level_a   <= next_c2a;
      conv2_level_b   <= next_c2b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Targets follow the registers one cycle later, two cycles after a commit
  pscd_level_select u_select (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .general_control    (general_control),
    .conv1_level_a      (conv1_level_a),
    .conv1_level_b      (conv1_level_b),
    .conv2_level_a      (conv2_level_a),
    .conv2_level_b      (conv2_level_b),
    .scaling_select_pin (filt[2]),
    .conv1_target       (conv1_target),
    .conv2_target       (conv2_target)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_restart;
    start_evt |=> state == PSCD_ADDR && bit_cnt == 4'h0 && !sda_oe;
  endproperty
  a_restart: assert property (p_restart) else $error("start not taken");

  property p_stop;
    stop_evt |=> state == PSCD_IDLE && !bus_busy && !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_busy;
    start_evt ##1 (!stop_evt)[*3] |-> bus_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped");

  property p_oe_low;
    ($changed(sda_oe) && !$past(start_evt) && !$past(stop_evt)) |-> !scl_f;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("data moved while clock high");

  property p_ack_hold;
    (tog_evt && bit_cnt == ACK_BIT_CNT && ack_pending) |-> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not held");

  property p_addr_miss;
    (tog_evt && state == PSCD_ADDR && bit_cnt == LAST_BIT_CNT && !start_evt
      && !stop_evt && link.shreg[7:1] != SLAVE_ADDR) |=> state == PSCD_IGNORE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

  property p_index_load;
    (tog_evt && state == PSCD_INDEX && bit_cnt == LAST_BIT_CNT && !start_evt
      && !stop_evt) |=> index == $past(link.shreg);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not loaded");

  property p_commit;
    (commit && is_mapped(index)) |=> reg_read(index) == $past(wdata);
  endproperty
  a_commit: assert property (p_commit) else $error("write not committed");

  property p_read_adv;
    (tog_evt && bit_cnt == ACK_BIT_CNT && state == PSCD_RDATA && !link.shreg[0]
      && !start_evt && !stop_evt) |=> index == 8'($past(index) + 8'h01);
  endproperty
  a_read_adv: assert property (p_read_adv) else $error("read index stuck");

  c_write: cover property (commit);
  c_read_ack: cover property (tog_evt && state == PSCD_RDATA && bit_cnt == ACK_BIT_CNT);
  c_rep_start: cover property (start_evt && bus_busy);

endmodule : pscd_top

// ==== testbench/pscd_host_model.sv ====
// Bus master model: drives the serial clock and pulls the data wire
`timescale 1ns/1ps
module pscd_host_model
  (
  // Bus wires
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
  );
  // Quarter of the 80 ns link period
  localparam time Q = 20ns;
  ////////////////////////////////////////////////////////////
  // Clock stands still high outside frames
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // One bit: data moves only while clock low, sampled mid-high
  task automatic bit_xfer(input logic b, output logic s);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_xfer
  // Start or repeated start; extra wait lets the slave let go first
  // Small skew keeps link edges off the core clock's rising edges
  task automatic start_cond;
    #3;
    sda_low = 1'b0;
    #(2*Q) scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start_cond
  // Stop: data rises while clock high, clock then stays high
  task automatic stop_cond;
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask : stop_cond
  // Byte out MSB first, then ninth clock with data released
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : write_byte
  // Byte in; a nack tells the slave the read is over
  task automatic read_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(~ack_it, s);
  endtask : read_byte
endmodule : pscd_host_model

// ==== testbench/tb.sv ====
// Self-checking bench for the serial register port and level selection
`timescale 1ns/1ps
module tb;
  import pscd_pkg::*;
  // Bus address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  // Design and bus signals
  logic               ref_clk;
  logic               rst;
  logic               scl;
  logic               host_low;
  logic               sda_wire;
  logic               sda_out;
  logic               sda_oe;
  logic               scaling_select_pin;
  logic [LEVEL_W-1:0] conv1_target;
  logic [LEVEL_W-1:0] conv2_target;
  logic               bus_busy;
  int                 err_total;
  int                 tests_run;
  // Open-drain wire with pull-up
  assign sda_wire = ~(host_low | (sda_oe & ~sda_out));
  ////////////////////////////////////////////////////////////
  pscd_top #(.SLAVE_ADDR(DEV_ADDR)) pscd_top_i
  (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .scl                (scl),
    .sda_in             (sda_wire),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .scaling_select_pin (scaling_select_pin),
    .conv1_target       (conv1_target),
    .conv2_target       (conv2_target),
    .bus_busy           (bus_busy)
  );
  pscd_host_model host_i
  (
    .scl     (scl),
    .sda_low (host_low),
    .sda     (sda_wire)
  );
  // Core clock, 8 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_clk
  // Index then a burst of data bytes, every byte acknowledged
  task automatic bus_write(input logic [7:0] idx, input logic [7:0] d [$]);
    logic a;
    host_i.start_cond();
    host_i.write_byte({DEV_ADDR, 1'b0}, a);
    check("write addr ack", a, 8'h01);
    host_i.write_byte(idx, a);
    check("index ack", a, 8'h01);
    foreach (d[i])
    begin
      host_i.write_byte(d[i], a);
      check("data ack", a, 8'h01);
    end
    host_i.stop_cond();
    wait_clk(2);
  endtask : bus_write
  // Index write, repeated start, burst read compared to expectation
  task automatic read_check(input logic [7:0] idx, input logic [7:0] e [$]);
    logic       a;
    logic [7:0] b;
    host_i.start_cond();
    host_i.write_byte({DEV_ADDR, 1'b0}, a);
    host_i.write_byte(idx, a);
    host_i.start_cond();
    host_i.write_byte({DEV_ADDR, 1'b1}, a);
    check("read addr ack", a, 8'h01);
    check("busy in frame", bus_busy, 8'h01);
    foreach (e[i])
    begin
      host_i.read_byte(i < e.size() - 1, b);
      check("read data", b, e[i]);
    end
    host_i.stop_cond();
    wait_clk(4);
    check("busy after stop", bus_busy, 8'h00);
  endtask : read_check
  ////////////////////////////////////////////////////////////
  // Reset state of outputs and registers
  task automatic t_reset;
    check("oe at reset", sda_oe, 8'h00);
    check("data out level", sda_out, 8'h00);
    check("conv1 at reset", conv1_target, 8'h00);
    read_check(OFS_GENERAL, '{8'h00});
    read_check(OFS_C1_A, '{8'h00, 8'h00, 8'h00, 8'h00});
  endtask : t_reset
  // Auto-increment burst, upper bits kept but not used as level
  task automatic t_burst;
    bus_write(OFS_C1_A, '{8'hF5, 8'h0A, 8'h1F, 8'h03});
    check("conv1 pin low", conv1_target, 8'h0A);
    check("conv2 bit clear", conv2_target, 8'h03);
    read_check(OFS_C1_A, '{8'hF5, 8'h0A, 8'h1F, 8'h03});
  endtask : t_burst
  // Every combination of both select bits and the pin
  task automatic t_select;
    for (int g = 3; g >= 0; g--)
      for (int p = 0; p < 2; p++)
      begin
        bus_write(OFS_GENERAL, '{8'(g << C1_SEL_BIT)});
        scaling_select_pin = p[0];
        wait_clk(8);
        check("conv1 level", conv1_target, p ? 8'h15 : 8'h0A);
        check("conv2 level", conv2_target, g[1] ? 8'h1F : 8'h03);
      end
  endtask : t_select
  // Foreign address, aborted byte, unmapped index, then recovery
  task automatic t_refused;
    logic a;
    host_i.start_cond();
    host_i.write_byte({DEV_ADDR ^ 7'h01, 1'b0}, a);
    check("foreign addr ack", a, 8'h00);
    host_i.write_byte(OFS_C2_B, a);
    host_i.write_byte(8'h11, a);
    host_i.stop_cond();
    host_i.start_cond();
    host_i.write_byte({DEV_ADDR, 1'b0}, a);
    host_i.write_byte(OFS_C2_B, a);
    for (int i = 0; i < 4; i++)
      host_i.bit_xfer(1'b1, a);
    host_i.stop_cond();
    wait_clk(4);
    check("conv2 after abort", conv2_target, 8'h03);
    check("busy after abort", bus_busy, 8'h00);
    bus_write(8'h05, '{8'hAA});
    read_check(8'h05, '{8'h00});
    bus_write(OFS_C2_B, '{8'h11});
    check("conv2 after commit", conv2_target, 8'h11);
  endtask : t_refused
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    err_total          = 0;
    tests_run          = 0;
    rst                = 1'b1;
    scaling_select_pin = 1'b0;
    wait_clk(6);
    rst = 1'b0;
    wait_clk(6);
    t_reset();
    t_burst();
    t_select();
    t_refused();
    final_report();
  end
  // Watchdog, well past the expected run of about 50 us
  initial
  begin
    #600us;
    err_total++;
    final_report();
  end
endmodule : tb
